/* File: src/scfd_pkg.sv */
// Package for the synthesizer configuration decode block.
// Assumes a 32-bit APB slave with byte addresses; fields sit in low bits.
package scfd_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_LOOP = 8'h00;
    localparam logic [7:0] ADDR_CTL = 8'h04;
    localparam logic [7:0] ADDR_TEST = 8'h08;
    localparam logic [7:0] ADDR_FAST = 8'h0C;
    localparam logic [7:0] ADDR_NUM = 8'h10;
    localparam logic [7:0] ADDR_DEN = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;

    typedef struct packed {
        logic [3:0] cap_b;
        logic [3:0] cap_a;
        logic [2:0] res_b;
        logic [2:0] res_a;
    } scfd_loop_t;

    typedef struct packed {
        logic frac_wide;
        logic doubler;
        logic pol;
        logic [4:0] pump;
        logic xtal;
        logic sleep;
        logic [1:0] mode;
    } scfd_ctl_t;

    typedef struct packed {
        logic [2:0] res_b;
        logic [2:0] res_a;
        logic [4:0] pump;
    } scfd_fast_t;

    // Inputs from the analog and divider side, all asynchronous
    typedef struct packed {
        logic fast_act;
        logic lock_ana;
        logic lock_dig;
        logic fb;
        logic ref_div;
        logic up;
        logic dn;
    } scfd_diag_t;

    // Reset values; the fractional width defaults to the wide form
    localparam scfd_loop_t LOOP_RST = 14'h0000;
    localparam scfd_ctl_t CTL_RST = 12'h800;
    localparam logic [3:0] TEST_RST = 4'h0;
    localparam scfd_fast_t FAST_RST = 11'h000;
    localparam logic [21:0] FRAC_RST = 22'h000000;
    localparam logic [21:0] FRAC_NARROW = 22'h0003FF;

    // Operating modes
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_EXT = 2'h1;
    localparam logic [1:0] MODE_DIV = 2'h2;
    localparam logic [1:0] MODE_TEST = 2'h3;

    // Test pin selections
    localparam logic [3:0] TP_HIZ = 4'h0;
    localparam logic [3:0] TP_HIGH = 4'h1;
    localparam logic [3:0] TP_LOW = 4'h2;
    localparam logic [3:0] TP_LD_PP = 4'h3;
    localparam logic [3:0] TP_LD_INV = 4'h4;
    localparam logic [3:0] TP_LD_OD = 4'h5;
    localparam logic [3:0] TP_ALD_OD = 4'h6;
    localparam logic [3:0] TP_ALD_PP = 4'h7;
    localparam logic [3:0] TP_FB = 4'h8;
    localparam logic [3:0] TP_FB_HALF = 4'h9;
    localparam logic [3:0] TP_REF = 4'hA;
    localparam logic [3:0] TP_REF_HALF = 4'hB;
    localparam logic [3:0] TP_UP = 4'hC;
    localparam logic [3:0] TP_DN = 4'hD;

    // Status bit positions
    localparam int ST_LOCK = 0;
    localparam int ST_ALOCK = 1;
    localparam int ST_FAST = 2;
    localparam int ST_RSV_A = 3;
    localparam int ST_RSV_B = 4;
    localparam int ST_DIV = 5;
    localparam int ST_PLL = 6;
    localparam int ST_VCO = 7;

    // Decode constants: ohms, picofarads, microamps
    localparam logic [15:0] RES_200 = 16'h00C8;
    localparam logic [15:0] RES_1K = 16'h03E8;
    localparam logic [15:0] RES_2K = 16'h07D0;
    localparam logic [15:0] RES_4K = 16'h0FA0;
    localparam logic [15:0] RES_16K = 16'h3E80;
    localparam logic [2:0] RES_MAX = 3'h4;
    localparam logic [7:0] CAPA_HI = 8'h05;
    localparam logic [7:0] CAPB_W3 = 8'h64;
    localparam logic [7:0] CAPB_W1 = 8'h14;
    localparam logic [7:0] CAPB_W0 = 8'h05;
    localparam logic [11:0] PUMP_UNIT = 12'h064;

    // Reserved resistor codes decode to zero
    function automatic logic [15:0] res_ohms(input logic [2:0] c);
        case (c)
            3'h0: res_ohms = RES_200;
            3'h1: res_ohms = RES_1K;
            3'h2: res_ohms = RES_2K;
            3'h3: res_ohms = RES_4K;
            3'h4: res_ohms = RES_16K;
            default: res_ohms = 16'h0000;
        endcase
    endfunction

    function automatic logic [11:0] pump_ua(input logic [4:0] c);
        pump_ua = ({7'h00, c} + 12'h001) * PUMP_UNIT;
    endfunction

endpackage

/* File: src/scfd_sync.sv */
// Two-flop synchroniser for asynchronous levels.
// Assumes inputs change slowly relative to mclk_i.
`timescale 1ns/1ns
module scfd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // scfd_sync

/* File: src/scfd_test_pin.sv */
// Test and lock-detect pin multiplexer with halving dividers.
// Assumes the diagnostic inputs are already synchronised to mclk_i.
`timescale 1ns/1ns
module scfd_test_pin (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Selection and sources
    input wire logic [3:0] sel_i,
    input wire scfd_pkg::scfd_diag_t diag_i,
    // Pin, enable low while driving
    output logic pin_o,
    output logic pin_oe_n_o
);
    logic fb_d_r;
    logic ref_d_r;
    logic fb_half_r;
    logic ref_half_r;

    wire fb_rise = diag_i.fb & ~fb_d_r;
    wire ref_rise = diag_i.ref_div & ~ref_d_r;

    // Returns {oe_n, level}; open drain only pulls low
    function automatic logic [1:0] drive(input logic [3:0] s,
                                         input scfd_pkg::scfd_diag_t d,
                                         input logic fr, input logic rr,
                                         input logic fh, input logic rh);
        case (s)
            scfd_pkg::TP_HIGH: drive = 2'h1;
            scfd_pkg::TP_LOW: drive = 2'h0;
            scfd_pkg::TP_LD_PP: drive = {1'b0, d.lock_dig};
            scfd_pkg::TP_LD_INV: drive = {1'b0, ~d.lock_dig};
            scfd_pkg::TP_LD_OD: drive = {d.lock_dig, 1'b0};
            scfd_pkg::TP_ALD_OD: drive = {d.lock_ana, 1'b0};
            scfd_pkg::TP_ALD_PP: drive = {1'b0, d.lock_ana};
            scfd_pkg::TP_FB: drive = {1'b0, fr};
            scfd_pkg::TP_FB_HALF: drive = {1'b0, fh};
            scfd_pkg::TP_REF: drive = {1'b0, rr};
            scfd_pkg::TP_REF_HALF: drive = {1'b0, rh};
            scfd_pkg::TP_UP: drive = {1'b0, d.up};
            scfd_pkg::TP_DN: drive = {1'b0, d.dn};
            default: drive = 2'h2;
        endcase
    endfunction

    wire [1:0] drive_nxt = drive(sel_i, diag_i, fb_rise, ref_rise,
                                 fb_half_r, ref_half_r);

    // Undivided edges give one-cycle pulses, halves give even duty
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            fb_d_r <= 1'b0;
            ref_d_r <= 1'b0;
            fb_half_r <= 1'b0;
            ref_half_r <= 1'b0;
            pin_o <= 1'b0;
            pin_oe_n_o <= 1'b1;
        end
        else
        begin
            fb_d_r <= diag_i.fb;
            ref_d_r <= diag_i.ref_div;
            fb_half_r <= fb_half_r ^ fb_rise;
            ref_half_r <= ref_half_r ^ ref_rise;
            pin_oe_n_o <= drive_nxt[1];
            pin_o <= drive_nxt[0];
        end
    end
endmodule // scfd_test_pin

/* File: src/scfd_top.sv */
// Configuration register bank and field decode for the synthesizer.
// Assumes an APB master on mclk_i and asynchronous analog-side inputs.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module scfd_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Asynchronous analog and divider inputs
    input wire logic [6:0] diag_i,
    // Loop filter
    output logic [15:0] res_a_ohm_o,
    output logic [15:0] res_b_ohm_o,
    output logic [7:0] cap_a_pf_o,
    output logic [7:0] cap_b_pf_o,
    output logic loop_apply_o,
    // Power and mode
    output logic div_en_o,
    output logic pll_en_o,
    output logic vco_en_o,
    output logic test_mode_o,
    output logic xtal_en_o,
    // Pump and reference
    output logic [11:0] pump_ua_o,
    output logic pump_pos_o,
    output logic ref_double_o,
    output logic ref_div_bypass_o,
    // Fraction
    output logic frac_wide_o,
    output logic [21:0] frac_num_o,
    output logic [21:0] frac_den_o,
    // Pins, enable low while driving
    output logic fast_lock_pin_o,
    output logic fast_lock_pin_oe_n_o,
    output logic test_lock_pin_o,
    output logic test_lock_pin_oe_n_o
);
    scfd_pkg::scfd_loop_t loop_r;
    scfd_pkg::scfd_ctl_t ctl_r;
    scfd_pkg::scfd_fast_t fast_r;
    scfd_pkg::scfd_diag_t diag_s;
    logic [3:0] test_r;
    logic [21:0] num_r;
    logic [21:0] den_r;
    logic [6:0] diag_sync;

    scfd_sync #(
        .W(7)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i(diag_i),
        .q_o(diag_sync)
    );

    assign diag_s = diag_sync;

    scfd_test_pin u_test_pin (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .sel_i(test_r),
        .diag_i(diag_s),
        .pin_o(test_lock_pin_o),
        .pin_oe_n_o(test_lock_pin_oe_n_o)
    );

    // Address decode
    wire sel_loop = paddr_i == scfd_pkg::ADDR_LOOP;
    wire sel_ctl = paddr_i == scfd_pkg::ADDR_CTL;
    wire sel_test = paddr_i == scfd_pkg::ADDR_TEST;
    wire sel_fast = paddr_i == scfd_pkg::ADDR_FAST;
    wire sel_num = paddr_i == scfd_pkg::ADDR_NUM;
    wire sel_den = paddr_i == scfd_pkg::ADDR_DEN;
    wire sel_stat = paddr_i == scfd_pkg::ADDR_STAT;
    wire mapped = sel_loop | sel_ctl | sel_test | sel_fast | sel_num
                  | sel_den | sel_stat;

    // One wait state: pready rises in the second access cycle
    wire access = psel_i & penable_i;
    wire first = access & ~pready_o;
    wire wr = access & pready_o & pwrite_i & mapped;

    // Decoded state
    wire awake = ~ctl_r.sleep;
    wire full = ctl_r.mode == scfd_pkg::MODE_FULL;
    wire fast = diag_s.fast_act;
    wire [2:0] ra_code = fast ? fast_r.res_a : loop_r.res_a;
    wire [2:0] rb_code = fast ? fast_r.res_b : loop_r.res_b;
    wire [4:0] pump_code = fast ? fast_r.pump : ctl_r.pump;
    wire apply_nxt = awake & full;
    wire div_nxt = awake;
    wire pll_nxt = awake & (ctl_r.mode != scfd_pkg::MODE_DIV);
    wire vco_nxt = pll_nxt & (ctl_r.mode != scfd_pkg::MODE_EXT);
    wire [21:0] frac_mask = ctl_r.frac_wide ? '1 : scfd_pkg::FRAC_NARROW;

    wire [7:0] cap_a_nxt = {5'h00, loop_r.cap_a[3:1]} * scfd_pkg::CAPA_HI
                           + {7'h00, loop_r.cap_a[0]};
    wire [7:0] cap_b_nxt =
        ({7'h00, loop_r.cap_b[3]} * scfd_pkg::CAPB_W3)
        + ({6'h00, loop_r.cap_b[2:1]} * scfd_pkg::CAPB_W1)
        + ({7'h00, loop_r.cap_b[0]} * scfd_pkg::CAPB_W0);

    wire [31:0] stat_word = {24'h000000, vco_en_o, pll_en_o, div_en_o,
                             loop_r.res_b > scfd_pkg::RES_MAX,
                             loop_r.res_a > scfd_pkg::RES_MAX,
                             diag_s.fast_act, diag_s.lock_ana,
                             diag_s.lock_dig};

    wire [31:0] rd_mux =
        sel_loop ? {18'h00000, loop_r} :
        sel_ctl ? {20'h00000, ctl_r} :
        sel_test ? {28'h0000000, test_r} :
        sel_fast ? {21'h000000, fast_r} :
        sel_num ? {10'h000, num_r} :
        sel_den ? {10'h000, den_r} :
        sel_stat ? stat_word : 32'h00000000;

    // APB answer
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end
        else
        begin
            pready_o <= first;
            pslverr_o <= first & ~mapped;
            prdata_o <= (first & ~pwrite_i) ? rd_mux : 32'h00000000;
        end
    end

    // Configuration fields; no hardware path ever alters them
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            loop_r <= scfd_pkg::LOOP_RST;
            ctl_r <= scfd_pkg::CTL_RST;
            test_r <= scfd_pkg::TEST_RST;
            fast_r <= scfd_pkg::FAST_RST;
            num_r <= scfd_pkg::FRAC_RST;
            den_r <= scfd_pkg::FRAC_RST;
        end
        else
        begin
            if (wr & sel_loop)
                loop_r <= pwdata_i[13:0];
            if (wr & sel_ctl)
                ctl_r <= pwdata_i[11:0];
            if (wr & sel_test)
                test_r <= pwdata_i[3:0];
            if (wr & sel_fast)
                fast_r <= pwdata_i[10:0];
            if (wr & sel_num)
                num_r <= pwdata_i[21:0];
            if (wr & sel_den)
                den_r <= pwdata_i[21:0];
        end
    end

    // Decoded outputs, one cycle behind the fields
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            res_a_ohm_o <= 16'h0000;
            res_b_ohm_o <= 16'h0000;
            cap_a_pf_o <= 8'h00;
            cap_b_pf_o <= 8'h00;
            loop_apply_o <= 1'b0;
            div_en_o <= 1'b0;
            pll_en_o <= 1'b0;
            vco_en_o <= 1'b0;
            test_mode_o <= 1'b0;
            xtal_en_o <= 1'b0;
            pump_ua_o <= 12'h000;
            pump_pos_o <= 1'b0;
            ref_double_o <= 1'b0;
            ref_div_bypass_o <= 1'b0;
            frac_wide_o <= 1'b1;
            frac_num_o <= scfd_pkg::FRAC_RST;
            frac_den_o <= scfd_pkg::FRAC_RST;
            fast_lock_pin_o <= 1'b0;
            fast_lock_pin_oe_n_o <= 1'b1;
        end
        else
        begin
            // Resistors and caps only count in full mode
            res_a_ohm_o <= apply_nxt ? scfd_pkg::res_ohms(ra_code)
                                     : 16'h0000;
            res_b_ohm_o <= apply_nxt ? scfd_pkg::res_ohms(rb_code)
                                     : 16'h0000;
            cap_a_pf_o <= apply_nxt ? cap_a_nxt : 8'h00;
            cap_b_pf_o <= apply_nxt ? cap_b_nxt : 8'h00;
            loop_apply_o <= apply_nxt;
            div_en_o <= div_nxt;
            pll_en_o <= pll_nxt;
            vco_en_o <= vco_nxt;
            test_mode_o <= awake & (ctl_r.mode == scfd_pkg::MODE_TEST);
            xtal_en_o <= awake & ctl_r.xtal;
            // Sleep gates usage only; stored fields stay intact
            pump_ua_o <= awake ? scfd_pkg::pump_ua(pump_code)
                               : 12'h000;
            pump_pos_o <= ctl_r.pol;
            ref_double_o <= awake & ctl_r.doubler;
            ref_div_bypass_o <= awake & ctl_r.doubler;
            frac_wide_o <= ctl_r.frac_wide;
            frac_num_o <= num_r & frac_mask;
            frac_den_o <= den_r & frac_mask;
            fast_lock_pin_o <= 1'b0;
            fast_lock_pin_oe_n_o <= ~fast;
        end
    end

    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_wr_test;
        psel_i && penable_i && pready_o && pwrite_i && sel_test;
    endsequence

    sequence s_full_awake;
        !ctl_r.sleep && ctl_r.mode == scfd_pkg::MODE_FULL;
    endsequence

    a_test_write: assert property (
        s_wr_test |=> test_r == $past(pwdata_i[3:0]))
        else $error("test select write not taken");

    a_field_hold: assert property (
        !(wr && sel_ctl) |=> ctl_r == $past(ctl_r))
        else $error("control field changed without a write");

    a_sleep_off: assert property (
        ctl_r.sleep |=> !div_en_o && !pll_en_o && !vco_en_o
                        && pump_ua_o == 12'h000)
        else $error("function active during sleep");

    a_mode_ext: assert property (
        !ctl_r.sleep && ctl_r.mode == scfd_pkg::MODE_EXT
        |=> div_en_o && pll_en_o && !vco_en_o)
        else $error("external oscillator mode enables wrong");

    a_mode_div: assert property (
        !ctl_r.sleep && ctl_r.mode == scfd_pkg::MODE_DIV
        |=> div_en_o && !pll_en_o && !vco_en_o)
        else $error("divider only mode enables wrong");

    a_res_fast: assert property (
        s_full_awake and diag_s.fast_act
        |=> res_a_ohm_o == scfd_pkg::res_ohms($past(fast_r.res_a))
            && fast_lock_pin_oe_n_o == 1'b0)
        else $error("fast lock resistor or pin wrong");

    a_res_norm: assert property (
        s_full_awake and !diag_s.fast_act
        |=> res_b_ohm_o == scfd_pkg::res_ohms($past(loop_r.res_b)))
        else $error("normal resistor B wrong");

    a_res_idle: assert property (
        ctl_r.mode != scfd_pkg::MODE_FULL |=> res_a_ohm_o == 16'h0000
                                            && cap_b_pf_o == 8'h00)
        else $error("loop filter applied outside full mode");

    a_pump_gain: assert property (
        !ctl_r.sleep && !diag_s.fast_act && ctl_r.pump == 5'h1F
        |=> pump_ua_o == 12'hC80)
        else $error("pump current at top code wrong");

    a_ref_bypass: assert property (
        !ctl_r.sleep && ctl_r.doubler
        |=> ref_div_bypass_o && ref_double_o)
        else $error("doubler on but divider not bypassed");

    a_frac_narrow: assert property (
        !frac_wide_o |-> frac_num_o[21:10] == 12'h000
                         && frac_den_o[21:10] == 12'h000)
        else $error("upper fraction bits used in narrow width");

    a_frac_reset: assert property (
        $rose(rst_n_i) |-> ctl_r.frac_wide)
        else $error("fraction width not wide after reset");

    a_test_high: assert property (
        test_r == scfd_pkg::TP_HIGH
        |=> test_lock_pin_o && !test_lock_pin_oe_n_o)
        else $error("test pin not driven high");

    a_cap_top: assert property (
        s_full_awake and loop_r.cap_b == 4'hF |=> cap_b_pf_o == 8'hA5)
        else $error("capacitor B top code wrong");

endmodule // scfd_top

/* File: verif/scfd_host.sv */
// Host model: APB master that programs the configuration bank.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
module scfd_host (
    // Clock
    input wire logic mclk_i,
    // APB master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h00000000;
    end

    // Bounded wait so a slave that never answers cannot hang the run
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e,
        output logic t);
        int n;
        begin
            n = 0;
            @(posedge mclk_i);
            psel_o <= 1'b1;
            pwrite_o <= w;
            paddr_o <= a;
            pwdata_o <= d;
            @(posedge mclk_i);
            penable_o <= 1'b1;
            do
            begin
                @(posedge mclk_i);
                n++;
            end
            while (pready_i !== 1'b1 && n < 20);
            r = prdata_i;
            e = pslverr_i;
            t = pready_i !== 1'b1;
            psel_o <= 1'b0;
            penable_o <= 1'b0;
        end
    endtask

    // Keyed modulation only works with the narrow fraction
    task automatic enter_fsk(input logic [31:0] ctl, output logic t);
        logic [31:0] r;
        logic e;
        begin
            xfer(1'b1, scfd_pkg::ADDR_CTL,
                ctl & 32'hFFFFF7FF, r, e, t);
        end
    endtask

    // Push-pull lock detect gives the cleanest fractional spurs
    task automatic program_defaults(output logic t);
        logic [31:0] r;
        logic e;
        begin
            xfer(1'b1, scfd_pkg::ADDR_TEST,
                32'h00000003, r, e, t);
        end
    endtask
endmodule // scfd_host

/* File: verif/scfd_bench.sv */
// Bench for the configuration bank: APB calls and decode checks.
// Assumes registered decode outputs and one APB wait state.
`timescale 1ns/1ns
module scfd_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, t, old;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0] diag = 7'h12;
    logic [6:0] msk;
    logic [15:0] res_a, res_b;
    logic [7:0] cap_a, cap_b;
    logic ap, div, pll, vco, tm, xtal, pos, dbl, byp, wide, fl, fl_oe_n;
    logic tp, tp_oe_n;
    logic [11:0] pump;
    logic [21:0] num, den;
    int miscompares = 0;
    int n_checks = 0;
    int hits;
    // Expected test pin {oe_n, level}: lock_dig 1, lock_ana 0, up 1, down 0
    localparam logic [1:0] TPX [0:15] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h0,
        2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2};

    scfd_top u_dut (.mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .diag_i(diag), .res_a_ohm_o(res_a),
        .res_b_ohm_o(res_b), .cap_a_pf_o(cap_a), .cap_b_pf_o(cap_b),
        .loop_apply_o(ap), .div_en_o(div), .pll_en_o(pll), .vco_en_o(vco),
        .test_mode_o(tm), .xtal_en_o(xtal), .pump_ua_o(pump),
        .pump_pos_o(pos), .ref_double_o(dbl), .ref_div_bypass_o(byp),
        .frac_wide_o(wide), .frac_num_o(num), .frac_den_o(den),
        .fast_lock_pin_o(fl), .fast_lock_pin_oe_n_o(fl_oe_n),
        .test_lock_pin_o(tp), .test_lock_pin_oe_n_o(tp_oe_n));
    scfd_host u_host (.mclk_i(mclk), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string s, input logic [63:0] x,
        input logic [63:0] g);
        n_checks++;
        if (g !== x)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic hp(input logic to);
        if (to !== 1'b0)
        begin
            miscompares++;
            give_verdict;
        end
    endtask
    task automatic st(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        begin
            u_host.xfer(1'b1, a, d, r, e, t);
            hp(t);
        end
    endtask
    task automatic rdc(input string s, input logic [7:0] a,
        input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        begin
            u_host.xfer(1'b0, a, 32'h00000000, r, e, t);
            hp(t);
            chk(s, x, r);
            chk(s, xe, e);
        end
    endtask
    function automatic logic [15:0] ohm(input int c);
        ohm = c > 4 ? 16'h0000 : c == 0 ? 16'h00C8
            : 16'h03E8 << (c - 1 + c / 4);
    endfunction

    initial
    begin
        repeat (100000) @(posedge mclk);
        hp(1'b1);
    end

    initial
    begin
        repeat (9) @(posedge mclk);
        #1;
        chk("rst_out", 4'hE,
            {wide, fl_oe_n, tp_oe_n, div | pll | ap});
        @(posedge mclk);
        rst_n <= 1'b1;
        rdc("ctl_rst", scfd_pkg::ADDR_CTL, 32'h800, 1'b0);
        for (int c = 0; c < 16; c++)
        begin
            wr(scfd_pkg::ADDR_LOOP,
                c << 10 | c << 6 | (15 - c) % 8 << 3 | c % 8);
            st(3);
            chk("res_a", ohm(c % 8), res_a);
            chk("res_b", ohm((15 - c) % 8), res_b);
            chk("cap_a", c / 2 * 5 + c % 2, cap_a);
            chk("cap_b", c / 8 * 100 + c / 4 % 2 * 40
                + c / 2 % 2 * 20 + c % 2 * 5, cap_b);
        end
        wr(scfd_pkg::ADDR_LOOP, 32'h00000451);
        for (int m = 0; m < 4; m++)
        begin
            wr(scfd_pkg::ADDR_CTL, 32'h00000800 | m);
            st(3);
            chk("mode_en",
                {m != 2, m % 3 == 0, m == 3, m == 0, 1'b1},
                {pll, vco, tm, ap, div});
            chk("loop_fm", m == 0 ? 48'h03E807D00105 : 48'h0,
                {res_a, res_b, cap_a, cap_b});
        end
        rdc("stat", scfd_pkg::ADDR_STAT, 32'h000000E1, 1'b0);
        wr(scfd_pkg::ADDR_CTL, 32'h00000C5C);
        st(3);
        chk("sleep", 0,
            {div, pll, vco, ap, xtal, dbl, byp, pump});
        rdc("keep", scfd_pkg::ADDR_LOOP, 32'h00000451, 1'b0);
        wr(scfd_pkg::ADDR_CTL, 32'h00000FF8);
        st(3);
        chk("pump_hi", 12'hC80, pump);
        chk("ref_on", 4'hF,
            {xtal, pos, dbl, byp});
        wr(scfd_pkg::ADDR_CTL, 32'h00000800);
        st(3);
        chk("pump_lo", 12'h064, pump);
        chk("ref_off", 4'h0,
            {xtal, pos, dbl, byp});
        wr(scfd_pkg::ADDR_NUM, 32'hFFFFFFFF);
        wr(scfd_pkg::ADDR_DEN, 32'h002AAAAA);
        st(3);
        chk("wide", {1'b1, 22'h3FFFFF, 22'h2AAAAA},
            {wide, num, den});
        u_host.enter_fsk(32'h00000800, t);
        hp(t);
        st(3);
        chk("narrow", {1'b0, 22'h0003FF, 22'h0002AA},
            {wide, num, den});
        wr(scfd_pkg::ADDR_CTL, 32'h00000800);
        wr(scfd_pkg::ADDR_FAST, 32'h00000349);
        @(posedge mclk);
        diag <= 7'h52;
        st(6);
        chk("fast", {12'h3E8, 32'h07D00FA0, 2'h0},
            {pump, res_a, res_b, fl, fl_oe_n});
        @(posedge mclk);
        diag <= 7'h12;
        st(6);
        chk("slow", {12'h064, 16'h03E8, 1'b1},
            {pump, res_a, fl_oe_n});
        for (int k = 0; k < 16; k++)
        begin
            if (k / 4 == 2)
                continue;
            wr(scfd_pkg::ADDR_TEST, k);
            st(6);
            chk("tp_oe",
                TPX[k][1], tp_oe_n);
            if (!TPX[k][1])
                chk("tp", TPX[k][0], tp);
        end
        for (int k = 0; k < 2; k++)
        begin
            msk = 7'h08 >> k;
            wr(scfd_pkg::ADDR_TEST, 8 + 2 * k);
            st(3);
            hits = 0;
            @(posedge mclk);
            diag <= diag | msk;
            repeat (10)
            begin
                @(posedge mclk);
                #1;
                hits += (tp === 1'b1);
            end
            chk("pulse", 1, hits);
            wr(scfd_pkg::ADDR_TEST, 9 + 2 * k);
            st(3);
            old = tp;
            @(posedge mclk);
            diag <= diag & ~msk;
            st(6);
            chk("half_hold", old, tp);
            @(posedge mclk);
            diag <= diag | msk;
            st(6);
            chk("half_flip", !old, tp);
            @(posedge mclk);
            diag <= diag & ~msk;
        end
        wr(scfd_pkg::ADDR_STAT, 32'h00000000);
        rdc("unmapped", 8'h1C, 32'h00000000, 1'b1);
        rdc("hold", scfd_pkg::ADDR_LOOP, 32'h00000451, 1'b0);
        u_host.program_defaults(t);
        hp(t);
        st(6);
        chk("ld_pp", 2'h1, {tp_oe_n, tp});
        give_verdict;
    end
endmodule // scfd_bench
